/* hdl/irq_status_latch_bank0.sv */
`timescale 1ns/100ps
module irq_status_latch_bank0 #(
  parameter int LANES = irq_status_pkg::LANES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [irq_status_pkg::ADDR_W-1:0] regAddr,
  input wire logic [irq_status_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [irq_status_pkg::DATA_W-1:0] regRdData,
  // Monitored conditions, asynchronous
  input wire irq_status_pkg::sources_s sources,
  input wire logic [LANES-1:0] laneFull,
  input wire logic [LANES-1:0] laneEmpty,
  // Interrupt and link control
  output logic irqN,
  output logic linkEnable
);

  localparam int DW = irq_status_pkg::DATA_W;

  typedef struct packed {
    irq_status_pkg::sources_s srcSync1;
    irq_status_pkg::sources_s srcSync2;
    logic [LANES-1:0] fullSync1;
    logic [LANES-1:0] fullSync2;
    logic [LANES-1:0] emptySync1;
    logic [LANES-1:0] emptySync2;
    logic [DW-1:0] latchMode;
    logic pairBMode;
    logic [DW-1:0] mask;
    logic pairBMask;
    logic linkEnable;
    logic [DW-1:0] rdData;
    logic irqN;
  } top_s;

  top_s st_ff;
  top_s nxt_st;

  irq_status_pkg::reg_req_s req;
  logic [DW-1:0] condVec;
  logic [DW-1:0] statusVec;
  logic [DW-1:0] pendVec;
  logic [DW-1:0] clearVec;
  logic pairBStatus;
  logic pairBPend;
  logic pairBClear;
  logic laneBufError;
  logic [LANES-1:0] fullFlags;
  logic [LANES-1:0] emptyFlags;

  // Address match, shared by write and read decoding
  function automatic logic hit(
    input logic [irq_status_pkg::ADDR_W-1:0] addr,
    input logic [irq_status_pkg::ADDR_W-1:0] ofs
  );
    return addr == ofs;
  endfunction

  // Lane flags wider than a byte would not fit one register
  function automatic logic [DW-1:0] toByte(input logic [LANES-1:0] flags);
    logic [DW-1:0] res;
    res = '0;
    for (int i = 0; i < LANES && i < DW; i++) begin
      res[i] = flags[i];
    end
    return res;
  endfunction

  always_comb begin
    req.addr = regAddr;
    req.wrData = regWrData;
    req.wrEn = regWrEn;
    req.rdEn = regRdEn;
  end

  // Live conditions, ordered as in the status byte
  always_comb begin
    condVec = '0;
    condVec[irq_status_pkg::BIT_CAL_OK] = st_ff.srcSync2.calibrationPassed;
    condVec[irq_status_pkg::BIT_CAL_BAD] = st_ff.srcSync2.calibrationFailed;
    condVec[irq_status_pkg::BIT_CONV_PLL_DROP] = st_ff.srcSync2.converterPllUnlocked;
    condVec[irq_status_pkg::BIT_CONV_PLL_OK] = st_ff.srcSync2.converterPllLocked;
    condVec[irq_status_pkg::BIT_LINK_PLL_DROP] = st_ff.srcSync2.linkPllUnlocked;
    condVec[irq_status_pkg::BIT_LINK_PLL_OK] = st_ff.srcSync2.linkPllLocked;
    condVec[irq_status_pkg::BIT_LANE_BUF_ERR] = laneBufError;
  end

  // Write-one-to-clear pulses for the status byte
  always_comb begin
    clearVec = '0;
    if (req.wrEn && hit(req.addr, irq_status_pkg::OFS_STATUS)) begin
      clearVec = req.wrData & irq_status_pkg::STATUS_USED;
    end
    pairBClear = req.wrEn && hit(req.addr, irq_status_pkg::OFS_PAIR_B_STATUS)
      && req.wrData[irq_status_pkg::BIT_PAIR_B];
  end

  assign statusVec[irq_status_pkg::BIT_RESERVED] = 1'b0;
  assign pendVec[irq_status_pkg::BIT_RESERVED] = 1'b0;

  genvar g;
  generate
    for (g = 1; g < DW; g++) begin : gen_cell
      status_bit_cell u_cell (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .condition(condVec[g]),
        .latchMode(st_ff.latchMode[g]),
        .clearReq(clearVec[g]),
        .statusBit(statusVec[g]),
        .pending(pendVec[g])
      );
    end
  endgenerate

  status_bit_cell u_pair_b_cell (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .condition(st_ff.srcSync2.pairBAlignTripped),
    .latchMode(st_ff.pairBMode),
    .clearReq(pairBClear),
    .statusBit(pairBStatus),
    .pending(pairBPend)
  );

  lane_buf_monitor #(
    .LANES(LANES)
  ) u_lane_mon (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .laneFull(st_ff.fullSync2),
    .laneEmpty(st_ff.emptySync2),
    .linkEnable(st_ff.linkEnable),
    .laneBufError(laneBufError),
    .fullFlags(fullFlags),
    .emptyFlags(emptyFlags)
  );

  always_comb begin
    nxt_st = st_ff;

    // Two-stage synchronisers for the monitored conditions and lane flags
    nxt_st.srcSync1 = sources;
    nxt_st.srcSync2 = st_ff.srcSync1;
    nxt_st.fullSync1 = laneFull;
    nxt_st.fullSync2 = st_ff.fullSync1;
    nxt_st.emptySync1 = laneEmpty;
    nxt_st.emptySync2 = st_ff.emptySync1;

    // Register writes
    if (req.wrEn) begin
      if (hit(req.addr, irq_status_pkg::OFS_LATCH_MODE_BANK0)) begin
        nxt_st.latchMode = req.wrData & irq_status_pkg::STATUS_USED;
      end else if (hit(req.addr, irq_status_pkg::OFS_LATCH_MODE_PAIR_B)) begin
        nxt_st.pairBMode = req.wrData[irq_status_pkg::BIT_PAIR_B];
      end else if (hit(req.addr, irq_status_pkg::OFS_MASK)) begin
        nxt_st.mask = req.wrData & irq_status_pkg::STATUS_USED;
      end else if (hit(req.addr, irq_status_pkg::OFS_PAIR_B_MASK)) begin
        nxt_st.pairBMask = req.wrData[irq_status_pkg::BIT_PAIR_B];
      end else if (hit(req.addr, irq_status_pkg::OFS_LINK_CTRL)) begin
        nxt_st.linkEnable = req.wrData[irq_status_pkg::BIT_LINK_EN];
      end
    end

    // Read data stands only in the cycle after the strobe
    nxt_st.rdData = '0;
    if (req.rdEn) begin
      if (hit(req.addr, irq_status_pkg::OFS_STATUS)) begin
        nxt_st.rdData = statusVec;
      end else if (hit(req.addr, irq_status_pkg::OFS_LATCH_MODE_BANK0)) begin
        nxt_st.rdData = st_ff.latchMode;
      end else if (hit(req.addr, irq_status_pkg::OFS_LATCH_MODE_PAIR_B)) begin
        nxt_st.rdData[irq_status_pkg::BIT_PAIR_B] = st_ff.pairBMode;
      end else if (hit(req.addr, irq_status_pkg::OFS_MASK)) begin
        nxt_st.rdData = st_ff.mask;
      end else if (hit(req.addr, irq_status_pkg::OFS_PAIR_B_STATUS)) begin
        nxt_st.rdData[irq_status_pkg::BIT_PAIR_B] = pairBStatus;
      end else if (hit(req.addr, irq_status_pkg::OFS_PAIR_B_MASK)) begin
        nxt_st.rdData[irq_status_pkg::BIT_PAIR_B] = st_ff.pairBMask;
      end else if (hit(req.addr, irq_status_pkg::OFS_LINK_CTRL)) begin
        nxt_st.rdData[irq_status_pkg::BIT_LINK_EN] = st_ff.linkEnable;
      end else if (hit(req.addr, irq_status_pkg::OFS_LANE_FULL)) begin
        nxt_st.rdData = toByte(fullFlags);
      end else if (hit(req.addr, irq_status_pkg::OFS_LANE_EMPTY)) begin
        nxt_st.rdData = toByte(emptyFlags);
      end
    end

    // Only latched bits can pend, so live-mode sources never pull the line
    nxt_st.irqN = !(|(pendVec & st_ff.mask) || (pairBPend && st_ff.pairBMask));
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
      st_ff.latchMode <= irq_status_pkg::RST_LATCH_MODE;
      st_ff.mask <= irq_status_pkg::RST_MASK;
      st_ff.pairBMask <= irq_status_pkg::RST_PAIR_B_MASK;
      st_ff.linkEnable <= irq_status_pkg::RST_LINK_EN;
      st_ff.rdData <= irq_status_pkg::RST_STATUS;
      st_ff.irqN <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign regRdData = st_ff.rdData;
  assign irqN = st_ff.irqN;
  assign linkEnable = st_ff.linkEnable;

endmodule // irq_status_latch_bank0

/* hdl/irq_status_pkg.sv */
package irq_status_pkg;

  // Bus and lane geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int LANES = 8;
  localparam int SOURCES = 7;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_LATCH_MODE_BANK0 = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_LATCH_MODE_PAIR_B = 12'h022;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h023;
  localparam logic [ADDR_W-1:0] OFS_MASK = 12'h028;
  localparam logic [ADDR_W-1:0] OFS_PAIR_B_STATUS = 12'h029;
  localparam logic [ADDR_W-1:0] OFS_PAIR_B_MASK = 12'h02A;
  localparam logic [ADDR_W-1:0] OFS_LINK_CTRL = 12'h300;
  localparam logic [ADDR_W-1:0] OFS_LANE_FULL = 12'h30C;
  localparam logic [ADDR_W-1:0] OFS_LANE_EMPTY = 12'h30D;

  // Field positions in the status byte and its mode and mask twins
  localparam int BIT_CAL_OK = 7;
  localparam int BIT_CAL_BAD = 6;
  localparam int BIT_CONV_PLL_DROP = 5;
  localparam int BIT_CONV_PLL_OK = 4;
  localparam int BIT_LINK_PLL_DROP = 3;
  localparam int BIT_LINK_PLL_OK = 2;
  localparam int BIT_LANE_BUF_ERR = 1;
  localparam int BIT_RESERVED = 0;
  localparam int BIT_PAIR_B = 0;
  localparam int BIT_LINK_EN = 0;

  // Reset values
  localparam logic [DATA_W-1:0] RST_STATUS = 8'h00;
  localparam logic [DATA_W-1:0] RST_LATCH_MODE = 8'h00;
  localparam logic [DATA_W-1:0] RST_MASK = 8'hFE;
  localparam logic RST_PAIR_B_MASK = 1'b1;
  localparam logic RST_LINK_EN = 1'b0;
  localparam logic [DATA_W-1:0] STATUS_USED = 8'hFE;

  // Monitored conditions from the analog and calibration side
  typedef struct packed {
    logic calibrationPassed;
    logic calibrationFailed;
    logic converterPllUnlocked;
    logic converterPllLocked;
    logic linkPllUnlocked;
    logic linkPllLocked;
    logic pairBAlignTripped;
  } sources_s;

  // Per-lane buffer flags from the deserializer side
  typedef struct packed {
    logic [LANES-1:0] full;
    logic [LANES-1:0] empty;
  } lane_flags_s;

  // One register access from the control port
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic wrEn;
    logic rdEn;
  } reg_req_s;

endpackage

/* hdl/lane_buf_monitor.sv */
`timescale 1ns/100ps
module lane_buf_monitor #(
  parameter int LANES = irq_status_pkg::LANES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Synchronised lane flags and link control
  input wire logic [LANES-1:0] laneFull,
  input wire logic [LANES-1:0] laneEmpty,
  input wire logic linkEnable,
  // Result
  output logic laneBufError,
  output logic [LANES-1:0] fullFlags,
  output logic [LANES-1:0] emptyFlags
);

  typedef struct packed {
    logic linkEnPrev;
    logic error;
    logic [LANES-1:0] full;
    logic [LANES-1:0] empty;
  } mon_s;

  mon_s mon_ff;
  mon_s nxt_mon;

  always_comb begin
    nxt_mon = mon_ff;
    nxt_mon.linkEnPrev = linkEnable;
    nxt_mon.full = laneFull;
    nxt_mon.empty = laneEmpty;
    if (linkEnable && !mon_ff.linkEnPrev) begin
      nxt_mon.error = 1'b0;
    end else if (linkEnable && ((|laneFull) || (|laneEmpty))) begin
      // Skips the enable cycle itself, where buffers are still priming
      nxt_mon.error = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mon_ff <= '0;
    end else begin
      mon_ff <= nxt_mon;
    end
  end

  assign laneBufError = mon_ff.error;
  assign fullFlags = mon_ff.full;
  assign emptyFlags = mon_ff.empty;

endmodule // lane_buf_monitor

/* hdl/status_bit_cell.sv */
`timescale 1ns/100ps
module status_bit_cell (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control
  input wire logic condition,
  input wire logic latchMode,
  input wire logic clearReq,
  // Result
  output logic statusBit,
  output logic pending
);

  typedef struct packed {
    logic prevCond;
    logic held;
  } cell_s;

  cell_s cell_ff;
  cell_s nxt_cell;

  always_comb begin
    nxt_cell = cell_ff;
    nxt_cell.prevCond = condition;
    if (!latchMode) begin
      nxt_cell.held = 1'b0;
    end else begin
      if (clearReq) begin
        nxt_cell.held = 1'b0;
      end
      // Set after clear so an edge in the clearing cycle survives
      if (condition && !cell_ff.prevCond) begin
        nxt_cell.held = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cell_ff <= '0;
    end else begin
      cell_ff <= nxt_cell;
    end
  end

  assign statusBit = latchMode ? cell_ff.held : condition;
  assign pending = cell_ff.held;

endmodule // status_bit_cell

/* verif/irq_status_chk.sv */
`timescale 1ns/100ps
module irq_status_chk #(
  parameter int LANES = irq_status_pkg::LANES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  // Conditions and outputs
  input wire irq_status_pkg::sources_s sources,
  input wire logic [LANES-1:0] laneFull,
  input wire logic [LANES-1:0] laneEmpty,
  input wire logic irqN,
  input wire logic linkEnable
);
  logic [7:0] modeFf;
  logic [7:0] maskFf;
  logic pairModeFf;
  logic cp;
  assign cp = sources.calibrationPassed;
  // Shadow of mode and mask, so properties know which bits latch
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      modeFf <= 8'h00;
      maskFf <= 8'hFE;
      pairModeFf <= 1'b0;
    end else if (regWrEn) begin
      if (regAddr == irq_status_pkg::OFS_LATCH_MODE_BANK0) modeFf <= regWrData;
      if (regAddr == irq_status_pkg::OFS_MASK) maskFf <= regWrData;
      if (regAddr == irq_status_pkg::OFS_LATCH_MODE_PAIR_B) pairModeFf <= regWrData[0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence calRiseLatched;
    modeFf[7] && maskFf[7] && $rose(cp) && !regWrEn ##1 !regWrEn [*3];
  endsequence
  sequence quietClear;
    !cp [*4] ##0 (regWrEn && regAddr == irq_status_pkg::OFS_STATUS && regWrData == 8'h80
      && modeFf == 8'h80 && !pairModeFf);
  endsequence
  rd_idle_zero_a: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
    else $error("read data not zero outside read cycle");
  reserved_zero_a: assert property ($past(regRdEn) && $past(regAddr) == 12'h023
    |-> !regRdData[0]) else $error("reserved status bit read one");
  link_write_a: assert property (regWrEn && regAddr == 12'h300
    |=> {7'h00, linkEnable} == ($past(regWrData) & 8'h01)) else $error("link enable wrong");
  live_status_a: assert property (regRdEn && regAddr == 12'h023 && !modeFf[7]
    && $stable(cp) && $past(cp, 2) == cp && $past(cp, 3) == cp |=> regRdData[7] == $past(cp))
    else $error("live calibration bit wrong");
  irq_latch_a: assert property (calRiseLatched |=> !irqN)
    else $error("latched rise did not pull interrupt low");
  irq_idle_a: assert property ((modeFf == 8'h00 && !pairModeFf) [*4] |-> irqN)
    else $error("interrupt low with all sources live");
  clear_w1c_a: assert property (quietClear |-> ##2 irqN)
    else $error("write one did not release interrupt");
  lane_full_a: assert property (($stable(laneFull) && $stable(laneEmpty)) [*4] ##0
    (regRdEn && regAddr == 12'h30C) |=> regRdData == 8'($past(laneFull)))
    else $error("lane full flags wrong");
endmodule // irq_status_chk

bind irq_status_latch_bank0 irq_status_chk #(.LANES(LANES)) irq_status_chk_i (
  .sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .sources(sources),
  .laneFull(laneFull), .laneEmpty(laneEmpty), .irqN(irqN), .linkEnable(linkEnable));

/* verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData;
  irq_status_pkg::sources_s sources = '0;
  logic [7:0] laneFull = 8'h00;
  logic [7:0] laneEmpty = 8'h00;
  logic irqN;
  logic linkEnable;
  int num_errors = 0;
  int checks_done = 0;
  integer seed = 32'heb7c_6bec;
  logic [6:0] src;
  logic [7:0] lf;
  logic [7:0] pm;
  logic [11:0] st;
  logic [11:0] md;
  logic [11:0] mk;

  always #5 sys_clk = ~sys_clk;

  irq_status_latch_bank0 #(.LANES(8)) irq_status_latch_bank0_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .sources(sources),
    .laneFull(laneFull), .laneEmpty(laneEmpty), .irqN(irqN), .linkEnable(linkEnable));

  function automatic logic [7:0] liveByte(input logic [6:0] s, input logic err);
    return {s[6:1], err, 1'b0};
  endfunction

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    // Data stand only until the next edge, so look mid-cycle
    @(negedge sys_clk);
    check(what, exp, regRdData);
    @(posedge sys_clk);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic close_out();
    $display("checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Far above the roughly 580 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    close_out();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(12'h023, 8'h00, "status reset");
    rd(12'h020, 8'h00, "mode reset");
    rd(12'h022, 8'h00, "pair mode reset");
    rd(12'h028, 8'hFE, "mask reset");
    wr(12'h023, 8'h01);
    rd(12'h023, 8'h00, "reserved bit");
    wr(12'h020, 8'hFE);
    rd(12'h020, 8'hFE, "mode readback");
    wr(12'h020, 8'h00);
    rd(12'h7FF, 8'h00, "unmapped read");
    for (int i = 0; i < 24; i++) begin
      src = (i == 0) ? 7'h7F : 7'($random(seed));
      sources <= src;
      idle(3);
      rd(12'h023, liveByte(src, 1'b0), "live status");
      rd(12'h029, {7'h00, src[0]}, "pair b live");
      check("irq live", 8'h01, {7'h00, irqN});
    end
    sources <= '0;
    // Index 0 is the pair-B trip, the rest map to status bits 2 to 7
    for (int b = 0; b < 7; b++) begin
      st = (b == 0) ? 12'h029 : 12'h023;
      md = (b == 0) ? 12'h022 : 12'h020;
      mk = (b == 0) ? 12'h02A : 12'h028;
      pm = (b == 0) ? 8'h01 : 8'h01 << (b + 1);
      wr(md, pm);
      idle(2);
      sources <= 7'h01 << b;
      idle(6);
      check("irq latched", 8'h00, {7'h00, irqN});
      sources <= '0;
      idle(4);
      rd(st, pm, "held bit");
      wr(mk, 8'h00);
      idle(2);
      check("irq masked", 8'h01, {7'h00, irqN});
      wr(mk, (b == 0) ? 8'h01 : 8'hFE);
      wr(st, 8'h00);
      rd(st, pm, "after zero write");
      wr(st, pm);
      idle(3);
      rd(st, 8'h00, "after clear");
      check("irq cleared", 8'h01, {7'h00, irqN});
      wr(md, 8'h00);
    end
    wr(12'h300, 8'h01);
    idle(3);
    rd(12'h023, 8'h00, "no lane error");
    lf = 8'($random(seed)) | 8'h01;
    laneFull <= lf;
    idle(4);
    rd(12'h30C, lf, "lane full");
    rd(12'h023, 8'h02, "lane error");
    laneFull <= 8'h00;
    laneEmpty <= ~lf;
    idle(4);
    rd(12'h30D, ~lf, "lane empty");
    laneEmpty <= 8'h00;
    idle(4);
    rd(12'h023, 8'h02, "error held");
    check("irq lane live", 8'h01, {7'h00, irqN});
    wr(12'h300, 8'h00);
    wr(12'h300, 8'h01);
    idle(3);
    rd(12'h023, 8'h00, "error removed");
    rd(12'h300, 8'h01, "link enable");
    check("link enable pin", 8'h01, {7'h00, linkEnable});
    // Held bit and pending interrupt must not survive a mid-run reset
    wr(12'h020, 8'h80);
    sources <= 7'h40;
    idle(6);
    check("irq before reset", 8'h00, {7'h00, irqN});
    sources <= '0;
    idle(2);
    reset_n <= 1'b0;
    idle(2);
    reset_n <= 1'b1;
    check("irq after reset", 8'h01, {7'h00, irqN});
    rd(12'h023, 8'h00, "status after reset");
    rd(12'h020, 8'h00, "mode after reset");
    check("link after reset", 8'h00, {7'h00, linkEnable});
    close_out();
  end
endmodule // tb_top
